//--- power_reset_control_regs.sv
/*
  power and reset control registers behind an apb slave.
  assumes cause and wake inputs are synchronous pulses, warn is a level from the
  comparator, and that cause flags and scratch words sit in a reset domain
  (rstnRetained) that rstn does not touch.
*/
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - cause flags accumulate across resets until cleared
// - writing one clears a cause flag
// - all flags zero means power-on or brownout
// - flags for pin, watchdog, soft, hang resets
// - flag for wake from deep-off by gpio
// - flag for wake from deep-off by debug
// - enable bit turns supply comparator on
// - threshold codes 4..15 map 1.7..2.8 V
// - scratch registers keep contents across resets
// - switcher enable bit selects dc/dc converter
// - bank registers at base plus index stride
// - per-section power bits reset to on
// - powered section always keeps its contents
// - unpowered section keeps contents only if retained
// - deep-off switches every ram section off
// - enabled comparator raises supply-warning event
module power_reset_control_regs (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic rstnRetained, // reset of the retained scratch domain, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire power_reset_pkg::event_in_t events, // reset causes, wake, warn level
  output power_reset_pkg::power_ctl_t ctl, // drive to analog and ram
  output logic irq // level interrupt
);
  localparam int RAM_BANK_BITS = power_reset_pkg::RAM_BANKS;

  // control state, loaded with its reset values by rstn
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic monitorEnable;
    logic [3:0] threshold;
    logic switcherEnable;
    logic [RAM_BANK_BITS-1:0][31:0] ram;
    power_reset_pkg::power_state_t pstate;
    logic warnSeen;
    logic irqStatus;
    logic irqEnable;
    logic irq;
    power_reset_pkg::power_ctl_t ctl;
  } state_t;

  // power-on state: cause flags and scratch words outlive rstn
  typedef struct packed {
    logic [31:0] cause;
    logic [31:0] s0;
    logic [31:0] s1;
  } scratch_t;

  // one select per register, from the bus address
  typedef struct packed {
    logic bad;
    logic cause;
    logic deepOff;
    logic cfg;
    logic scratch0;
    logic scratch1;
    logic switcher;
    logic irqStatus;
    logic irqEnable;
    logic irqClear;
    logic bank;
    logic [2:0] bankIdx;
  } sel_t;

  state_t st;
  state_t next_st;
  scratch_t sc;
  scratch_t next_sc;

  // decode a bank register; returns bank index plus hit flag
  function automatic logic [3:0] bank_hit(input logic [11:0] a);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < power_reset_pkg::RAM_BANKS; i++) begin
      if (a == power_reset_pkg::RAM_BASE_OFS + 12'(i) * power_reset_pkg::RAM_STRIDE) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : bank_hit

  // effective section power after deep-off override
  function automatic logic [1:0] section_on(input logic [31:0] r, input logic off);
    return off ? 2'b00 : r[1:0];
  endfunction : section_on

  // full address decode; anything unmapped or unaligned is an error
  function automatic sel_t decode(input logic [31:0] a);
    sel_t s;
    logic [3:0] b;
    s = '0;
    b = bank_hit(a[11:0]);
    if (a[31:12] != 20'h00000 || a[1:0] != 2'b00) begin
      s.bad = 1'b1;
    end else if (a[11:0] == power_reset_pkg::RESET_CAUSE_OFS) begin
      s.cause = 1'b1;
    end else if (a[11:0] == power_reset_pkg::DEEP_OFF_OFS) begin
      s.deepOff = 1'b1;
    end else if (a[11:0] == power_reset_pkg::SUPPLY_CFG_OFS) begin
      s.cfg = 1'b1;
    end else if (a[11:0] == power_reset_pkg::SCRATCH0_OFS) begin
      s.scratch0 = 1'b1;
    end else if (a[11:0] == power_reset_pkg::SCRATCH1_OFS) begin
      s.scratch1 = 1'b1;
    end else if (a[11:0] == power_reset_pkg::SWITCHER_OFS) begin
      s.switcher = 1'b1;
    end else if (a[11:0] == power_reset_pkg::IRQ_STATUS_OFS) begin
      s.irqStatus = 1'b1;
    end else if (a[11:0] == power_reset_pkg::IRQ_ENABLE_OFS) begin
      s.irqEnable = 1'b1;
    end else if (a[11:0] == power_reset_pkg::IRQ_CLEAR_OFS) begin
      s.irqClear = 1'b1;
    end else if (b[3]) begin
      s.bank = 1'b1;
      s.bankIdx = b[2:0];
    end else begin
      s.bad = 1'b1;
    end
    return s;
  endfunction : decode

  // map source pulses onto their flag positions
  function automatic logic [31:0] cause_bits(input logic [5:0] p);
    logic [31:0] r;
    r = 32'h00000000;
    r[power_reset_pkg::CAUSE_PIN] = p[0];
    r[power_reset_pkg::CAUSE_DOG] = p[1];
    r[power_reset_pkg::CAUSE_SOFT] = p[2];
    r[power_reset_pkg::CAUSE_HANG] = p[3];
    r[power_reset_pkg::CAUSE_GPIO_WAKE] = p[4];
    r[power_reset_pkg::CAUSE_DEBUG_WAKE] = p[5];
    return r;
  endfunction : cause_bits

  // single-bit register as a read word, reserved bits zero
  function automatic logic [31:0] bit_word(input logic b);
    return {31'h0, b};
  endfunction : bit_word

  // supply monitor configuration as a read word
  function automatic logic [31:0] cfg_word(input logic en, input logic [3:0] thr);
    return {27'h0, thr, en};
  endfunction : cfg_word

  sel_t sel;
  logic access;
  logic wr;
  logic rd;
  logic warnEdge;
  logic [31:0] causeSet;

  always_comb begin
    next_st = st;
    next_sc = sc;
    sel = decode(paddr);
    access = psel && penable && !st.pready;
    wr = access && pwrite;
    rd = access && !pwrite;
    warnEdge = events.warnLevel && !st.warnSeen && st.monitorEnable;
    causeSet = cause_bits(events.cause);

    // answer one cycle after the first access cycle, for one cycle only
    next_st.pready = access;
    next_st.pslverr = access && sel.bad;
    next_st.prdata = 32'h00000000;
    next_st.warnSeen = events.warnLevel && st.monitorEnable;

    // read path; write-only and unmapped registers read zero
    if (rd && !sel.bad) begin
      if (sel.cause) begin
        next_st.prdata = sc.cause;
      end else if (sel.cfg) begin
        next_st.prdata = cfg_word(st.monitorEnable, st.threshold);
      end else if (sel.scratch0) begin
        next_st.prdata = sc.s0;
      end else if (sel.scratch1) begin
        next_st.prdata = sc.s1;
      end else if (sel.switcher) begin
        next_st.prdata = bit_word(st.switcherEnable);
      end else if (sel.irqStatus) begin
        next_st.prdata = bit_word(st.irqStatus);
      end else if (sel.irqEnable) begin
        next_st.prdata = bit_word(st.irqEnable);
      end else if (sel.bank) begin
        next_st.prdata = st.ram[sel.bankIdx];
      end else begin
        next_st.prdata = 32'h00000000;
      end
    end

    // write path; an error access changes nothing
    if (wr && !sel.bad) begin
      if (sel.cause) begin
        next_sc.cause = sc.cause & ~(pwdata & power_reset_pkg::CAUSE_MASK);
      end else if (sel.deepOff) begin
        if (pwdata == power_reset_pkg::DEEP_OFF_ENTER) begin
          next_st.pstate = power_reset_pkg::DEEP_OFF;
        end
      end else if (sel.cfg) begin
        next_st.monitorEnable = pwdata[0];
        next_st.threshold = pwdata[power_reset_pkg::THRESH_LSB +: 4];
      end else if (sel.scratch0) begin
        next_sc.s0 = pwdata;
      end else if (sel.scratch1) begin
        next_sc.s1 = pwdata;
      end else if (sel.switcher) begin
        next_st.switcherEnable = pwdata[0];
      end else if (sel.irqEnable) begin
        next_st.irqEnable = pwdata[0];
      end else if (sel.irqClear) begin
        if (pwdata[0]) begin
          next_st.irqStatus = 1'b0;
        end
      end else if (sel.bank) begin
        next_st.ram[sel.bankIdx] = pwdata & power_reset_pkg::RAM_MASK;
      end
    end

    // set wins over clear
    if (warnEdge) begin
      next_st.irqStatus = 1'b1;
    end
    // a source pulse beats a software clear in the same cycle
    next_sc.cause = next_sc.cause | causeSet;
    // only a wake pulse or rstn takes the block out of deep-off
    if (st.pstate == power_reset_pkg::DEEP_OFF && events.wake) begin
      next_st.pstate = power_reset_pkg::RUN;
    end
    next_st.irq = next_st.irqStatus && next_st.irqEnable;
    next_st.ctl.monitorEnable = next_st.monitorEnable;
    next_st.ctl.threshold = next_st.threshold;
    next_st.ctl.thresholdValid = next_st.threshold >= power_reset_pkg::THRESH_MIN;
    next_st.ctl.switcherEnable = next_st.switcherEnable;
    next_st.ctl.deepOff = next_st.pstate == power_reset_pkg::DEEP_OFF;
    for (int i = 0; i < power_reset_pkg::RAM_BANKS; i++) begin
      next_st.ctl.ramPower[2*i +: 2] = section_on(next_st.ram[i], next_st.ctl.deepOff);
      // retained when on or when retention bit set
      next_st.ctl.ramRetain[2*i +: 2] = next_st.ctl.ramPower[2*i +: 2] |
        next_st.ram[i][power_reset_pkg::RAM_RET_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.pstate <= power_reset_pkg::RUN;
      for (int i = 0; i < power_reset_pkg::RAM_BANKS; i++) begin
        st.ram[i] <= power_reset_pkg::RAM_POWER_RESET & power_reset_pkg::RAM_MASK;
      end
      st.ctl.ramPower <= 16'hFFFF;
      st.ctl.ramRetain <= 16'hFFFF;
      st.ctl.thresholdValid <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // cause flags and scratch words: cleared at power-on only, so they survive rstn
  always_ff @(posedge clk or negedge rstnRetained) begin
    if (!rstnRetained) begin
      sc <= '0;
    end else begin
      sc <= next_sc;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign ctl = st.ctl;
  assign irq = st.irq;
endmodule : power_reset_control_regs

//--- power_reset_control_regs_test.sv
/* self-checking bench for the power reset register block.
   drives apb, cause pulses and warn level itself. */
`timescale 1ns/1ps
module power_reset_control_regs_test;
  logic clk = 1'h0, rstn = 1'h0, rstnRetained = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, irq;
  logic [31:0] paddr = '0, pwdata = '0, prdata, v, w;
  logic [64:0] x;
  logic [64:0] expQ[$];
  power_reset_pkg::event_in_t events = '0;
  power_reset_pkg::power_ctl_t ctl;
  int n_errors, n_checks, cyc, seed = 32'h5DF9;
  initial forever #50 clk = ~clk;
  power_reset_control_regs power_reset_control_regs_inst (.clk, .rstn, .rstnRetained, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .events, .ctl, .irq);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic bus(input logic wr, input logic [31:0] a, d, m, input logic er);
    expQ.push_back({er, m, d});
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    bus(1'h1, a, d, '0, 1'h0);
  endtask : wr
  task automatic rd(input logic [31:0] a, e);
    bus(1'h0, a, e, '1, 1'h0);
  endtask : rd
  always @(posedge clk) begin
    if (pready === 1'h1) begin
      x = expQ.pop_front();
      chk("prdata", x[31:0] & x[63:32], prdata & x[63:32]);
      chk("pslverr", {31'h0, x[64]}, {31'h0, pslverr});
    end
    if (++cyc > 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    rstnRetained <= 1'h1;
    rd(32'h400, '0);
    rd(32'h510, '0);
    rd(32'h578, '0);
    chk("ramPower", 32'h0000FFFF, {16'h0, ctl.ramPower});
    v = '0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      events.cause <= 6'h1 << i;
      @(posedge clk);
      events.cause <= 6'h0;
      v |= (i < 4) ? 32'h1 << i : 32'h10000 << (i - 4);
      rd(32'h400, v);
    end
    wr(32'h400, 32'h1);
    wr(32'h400, 32'h0);
    rd(32'h400, v & 32'hFFFFFFFE);
    for (int i = 0; i < 6; i++) begin
      w = {27'h0, (i < 2) ? 4'(13 * i + 2) : 4'($random(seed)), 1'h1};
      wr(32'h510, w);
      rd(32'h510, w);
      chk("valid", {31'h0, w[4:1] >= 4'h4}, {31'h0, ctl.thresholdValid});
    end
    w = $random(seed);
    wr(32'h51C, w);
    wr(32'h520, ~w);
    @(posedge clk);
    rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    rd(32'h51C, w);
    rd(32'h520, ~w);
    rd(32'h400, v & 32'hFFFFFFFE);
    wr(32'h578, 32'h1);
    rd(32'h578, 32'h1);
    for (int n = 0; n < 8; n++) begin
      w = $random(seed) & 32'h00030003;
      wr(32'h900 + 32'(n) * 32'h10, w);
      rd(32'h900 + 32'(n) * 32'h10, w);
      chk("power", {30'h0, w[1:0]}, {30'h0, ctl.ramPower[2*n+:2]});
      chk("retain", {30'h0, w[1:0] | w[17:16]}, {30'h0, ctl.ramRetain[2*n+:2]});
    end
    bus(1'h0, 32'h904, '0, '0, 1'h1);
    bus(1'h1, 32'h402, '0, '0, 1'h1);
    wr(32'h510, 32'h9);
    wr(32'h604, 32'h1);
    events.warnLevel <= 1'h1;
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(32'h600, 32'h1);
    wr(32'h608, 32'h1);
    wr(32'h604, 32'h0);
    events.warnLevel <= 1'h0;
    @(posedge clk);
    events.warnLevel <= 1'h1;
    rd(32'h600, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    wr(32'h500, 32'h1);
    @(posedge clk);
    chk("deepOff", 32'h1, {31'h0, ctl.deepOff});
    chk("ramOff", 32'h0, {16'h0, ctl.ramPower});
    events.wake <= 1'h1;
    @(posedge clk);
    events.wake <= 1'h0;
    repeat (2) @(posedge clk);
    chk("deepOff", 32'h0, {31'h0, ctl.deepOff});
    print_verdict();
  end
endmodule : power_reset_control_regs_test

//--- power_reset_monitor.sv
/* checker on the ports of the power reset block.
   bound to power_reset_control_regs after the module. */
`timescale 1ns/1ps
module power_reset_monitor (
  input wire logic clk, // clock
  input wire logic rstn, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [31:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire power_reset_pkg::power_ctl_t ctl // controls
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire r = pready && !pwrite;
  sequence offWr;
    psel && penable && !pready && pwrite && paddr == 32'h500 && pwdata == 32'h1;
  endsequence
  ready_late_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  thresh_ok_a: assert property (ctl.thresholdValid == (ctl.threshold >= 4'h4))
    else $error("threshold valid wrong");
  deep_ram_a: assert property (ctl.deepOff |-> ctl.ramPower == 16'h0)
    else $error("ram on in deep-off");
  deep_enter_a: assert property (offWr |=> ##[0:1] ctl.deepOff)
    else $error("deep-off not entered");
  bad_addr_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned accepted");
  switch_rd_a: assert property (r && paddr == 32'h578 |->
    prdata == {31'h0, ctl.switcherEnable}) else $error("switcher readback");
  cfg_rd_a: assert property (r && paddr == 32'h510 |->
    prdata == {27'h0, ctl.threshold, ctl.monitorEnable}) else $error("cfg readback");
  ram_rd_a: assert property (r && paddr == 32'h900 && !ctl.deepOff |->
    prdata[1:0] == ctl.ramPower[1:0]) else $error("bank readback");
endmodule : power_reset_monitor

bind power_reset_control_regs power_reset_monitor power_reset_monitor_inst (
  .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ctl);

//--- power_reset_pkg.sv
/*
  constants and types for the power and reset control register block.
  assumes an apb slave on a 32-bit bus, byte addressed.
*/
package power_reset_pkg;
  localparam logic [11:0] RESET_CAUSE_OFS = 12'h400;
  localparam logic [11:0] DEEP_OFF_OFS = 12'h500;
  localparam logic [11:0] SUPPLY_CFG_OFS = 12'h510;
  localparam logic [11:0] SCRATCH0_OFS = 12'h51C;
  localparam logic [11:0] SCRATCH1_OFS = 12'h520;
  localparam logic [11:0] SWITCHER_OFS = 12'h578;
  localparam logic [11:0] RAM_BASE_OFS = 12'h900;
  localparam logic [11:0] RAM_STRIDE = 12'h010;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h600;
  localparam logic [11:0] IRQ_ENABLE_OFS = 12'h604;
  localparam logic [11:0] IRQ_CLEAR_OFS = 12'h608;
  localparam int RAM_BANKS = 8;
  localparam logic [31:0] DEEP_OFF_ENTER = 32'h00000001;
  localparam logic [31:0] RAM_POWER_RESET = 32'h0000FFFF;
  localparam logic [31:0] ZERO_RESET = 32'h00000000;
  localparam int CAUSE_PIN = 0;
  localparam int CAUSE_DOG = 1;
  localparam int CAUSE_SOFT = 2;
  localparam int CAUSE_HANG = 3;
  localparam int CAUSE_GPIO_WAKE = 16;
  localparam int CAUSE_DEBUG_WAKE = 17;
  localparam logic [31:0] CAUSE_MASK = 32'h0003000F;
  localparam int THRESH_LSB = 1;
  localparam logic [3:0] THRESH_MIN = 4'h4;
  localparam logic [31:0] SUPPLY_CFG_MASK = 32'h0000001F;
  localparam logic [31:0] RAM_MASK = 32'h00030003;
  localparam int RAM_RET_LSB = 16;

  typedef enum logic [1:0] {
    RUN = 2'b01,
    DEEP_OFF = 2'b10
  } power_state_t;

  typedef struct packed {
    logic [5:0] cause;
    logic wake;
    logic warnLevel;
  } event_in_t;

  typedef struct packed {
    logic monitorEnable;
    logic [3:0] threshold;
    logic thresholdValid;
    logic switcherEnable;
    logic [15:0] ramPower;
    logic [15:0] ramRetain;
    logic deepOff;
  } power_ctl_t;
endpackage : power_reset_pkg
